// File: pci_isolation_reset_wake_control.sv
/*
  isolation, internal initialization and wake event control.
  assumes CORE_CLK runs from auxiliary power and never stops; PCI pins are asynchronous.
  assumes the frame parser outside flags class hits per byte; this block only filters.
  assumes POWER_STATE, PME_ENABLE and the MAC configure bits are same-clock levels.
  assumes LINK_VALID comes from logic on CORE_CLK, so it needs no synchroniser.
  assumes the alternate power-on reset pin may toggle at any time, so it is filtered.
  the PCI clock is never used here: it may be missing while the bus is powered off.
  a user must hold CE high for the synchronisers to track the pins at all.
*/
`timescale 1ns/1ps
module pci_isolation_reset_wake_control (
  input wire logic CORE_CLK, // auxiliary clock
  input wire logic RST, // synchronous reset, high
  input wire logic CE, // clock enable
  input wire logic ALTERNATE_POR_N, // alternate power-on reset, async pin
  input wire logic ISOLATE_N, // PCI power good, low isolates
  input wire logic PCI_RST_N, // PCI reset pin
  input wire logic AUX_SUPPLY_SENSE, // aux supply present
  input wire logic [1:0] POWER_STATE, // D state from config space
  input wire logic PME_ENABLE, // event-enable bit
  input wire logic PME_STATUS_CLR, // clear pending event, pulse
  input wire logic CFG_LINK_WAKE_EN, // link wake set by MAC configure
  input wire logic CFG_PKT_WAKE_EN, // packet wake set by MAC configure
  input wire logic [4:0] CFG_CLASS_EN, // per-class enable
  input wire logic LINK_VALID, // link status, same clock
  input wire logic RX_BYTE_VALID, // received byte strobe
  input wire logic RX_FRAME_START, // first byte of frame
  input wire logic RX_FRAME_END, // frame end pulse
  input wire logic [4:0] RX_CLASS_HIT, // parser class hits, per byte
  input wire logic [7:0] RX_BYTE, // received byte
  input wire logic [7:0] PCI_OUT_DATA, // core PCI outputs
  input wire logic [7:0] PCI_OUT_EN_REQ, // core PCI enables
  input wire logic [7:0] PCI_IN_PINS, // raw PCI inputs
  output logic [7:0] PCI_IN_GATED, // inputs seen by core
  output logic [7:0] PCI_PIN_O, // PCI pin outputs
  output logic [7:0] PCI_PIN_OE, // PCI pin enables
  output logic PME_N_O, // event pin output
  output logic PME_N_OE, // event pin enable
  output logic INIT, // internal initialization
  output logic EVENT_CTX_RESET, // clears event context
  output logic PME_STATUS, // pending event flag
  output logic BUS_WAKE, // B3 to B0 pulse
  output logic [7:0] WAKE_PKT_BYTE, // stored frame byte
  output logic [7:0] WAKE_PKT_LEN // stored frame length
);
  logic [2:0] iso_sync_ff, nxt_iso_sync;
  logic [2:0] prst_sync_ff, nxt_prst_sync;
  logic [2:0] por_sync_ff, nxt_por_sync;
  logic iso_ff, nxt_iso;
  logic prst_ff, nxt_prst;
  logic por_n_ff, nxt_por_n;
  logic link_ff, nxt_link;
  iso_rst_pkg::bus_state_t bus_ff, nxt_bus;
  logic init_ff, nxt_init;
  logic ctx_rst_ff, nxt_ctx_rst;
  logic wake_ff, nxt_wake;
  logic pme_ff, nxt_pme;
  logic [7:0] cnt_ff, nxt_cnt;
  logic [4:0] hit_ff, nxt_hit;
  logic [7:0] len_ff, nxt_len;
  logic [7:0] pkt_mem [0:127];
  logic [7:0] pkt_q_ff;
  logic iso_rise, iso_fall, prst_rise;
  logic pci_live, in_window, pkt_match, link_evt;
  logic [4:0] class_ok;

  // three-stage synchronisers, change counted once stages 2 and 3 agree
  // stage 1 may go metastable, so only stages 2 and 3 feed the filtered level
  // a one-cycle glitch on a pin never reaches the filtered level
  // cost: every pin change is seen three to four edges late
  always_comb begin
    nxt_iso_sync = {iso_sync_ff[1:0], ISOLATE_N};
    nxt_prst_sync = {prst_sync_ff[1:0], PCI_RST_N};
    nxt_por_sync = {por_sync_ff[1:0], ALTERNATE_POR_N};
    nxt_iso = (iso_sync_ff[1] == iso_sync_ff[2]) ? iso_sync_ff[2] : iso_ff;
    nxt_prst = (prst_sync_ff[1] == prst_sync_ff[2]) ? prst_sync_ff[2] : prst_ff;
    nxt_por_n = (por_sync_ff[1] == por_sync_ff[2]) ? por_sync_ff[2] : por_n_ff;
  end

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      iso_sync_ff <= iso_rst_pkg::SYNC_RESET;
      prst_sync_ff <= iso_rst_pkg::SYNC_RESET;
      por_sync_ff <= iso_rst_pkg::SYNC_RESET;
      iso_ff <= 1'b0;
      prst_ff <= 1'b0;
      por_n_ff <= 1'b0;
    end else if (CE) begin
      iso_sync_ff <= nxt_iso_sync;
      prst_sync_ff <= nxt_prst_sync;
      por_sync_ff <= nxt_por_sync;
      iso_ff <= nxt_iso;
      prst_ff <= nxt_prst;
      por_n_ff <= nxt_por_n;
    end
  end

  // both isolate edges and the reset trailing edge, seen from the filtered levels
  // edges come from the filtered level, never from a raw pin, so one edge = one pulse
  // reset edge is masked while isolated or on aux supply: the pin is undefined then
  assign iso_rise = nxt_iso & ~iso_ff;
  assign iso_fall = ~nxt_iso & iso_ff;
  assign prst_rise = nxt_prst & ~prst_ff & iso_ff & ~AUX_SUPPLY_SENSE;

  // bus power tracking and initialization generation
  // bus_off: no PCI power; bus_reset: powered, reset held; bus_on: running
  // a falling isolate level always wins and returns the tracker to bus_off
  // init is a level in D0 to D2 and a pulse in D3, where the reset pin may float
  // an isolate trailing edge always pulses init, whatever the power state
  always_comb begin
    nxt_bus = bus_ff;
    nxt_wake = 1'b0;
    nxt_init = 1'b0;
    nxt_ctx_rst = 1'b0;
    case (bus_ff)
      iso_rst_pkg::BUS_OFF: begin
        if (nxt_iso) begin
          nxt_bus = iso_rst_pkg::BUS_RESET;
        end
      end
      iso_rst_pkg::BUS_RESET: begin
        if (prst_rise) begin
          nxt_bus = iso_rst_pkg::BUS_ON;
          nxt_wake = 1'b1;
        end
      end
      iso_rst_pkg::BUS_ON: begin
        if (~nxt_prst & ~AUX_SUPPLY_SENSE) begin
          nxt_bus = iso_rst_pkg::BUS_RESET;
        end
      end
      default: nxt_bus = iso_rst_pkg::BUS_OFF;
    endcase
    if (iso_fall) begin
      nxt_bus = iso_rst_pkg::BUS_OFF;
    end
    // level init in D0-D2, edge init in D3, isolate edge always
    if (iso_ff & ~AUX_SUPPLY_SENSE) begin
      if (POWER_STATE != iso_rst_pkg::DSTATE_D3) begin
        nxt_init = ~nxt_prst;
      end else begin
        nxt_init = prst_rise;
      end
    end
    if (iso_rise | ~nxt_por_n) begin
      nxt_init = 1'b1;
    end
    // event context survives init unless events disabled outside D3, or power-on reset
    nxt_ctx_rst = ~nxt_por_n | (nxt_init & ~PME_ENABLE & POWER_STATE != iso_rst_pkg::DSTATE_D3);
  end

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      bus_ff <= iso_rst_pkg::BUS_OFF;
      wake_ff <= 1'b0;
      init_ff <= 1'b1;
      ctx_rst_ff <= 1'b1;
    end else if (CE) begin
      bus_ff <= nxt_bus;
      wake_ff <= nxt_wake;
      init_ff <= nxt_init;
      ctx_rst_ff <= nxt_ctx_rst;
    end
  end

  // PCI pins live only when powered and either out of reset or on aux supply
  // while init runs the core is not ready, so its outputs stay floating too
  // gated inputs read as zero, so a floating bus cannot look like a request
  assign pci_live = iso_ff & (prst_ff | AUX_SUPPLY_SENSE) & ~init_ff;
  assign PCI_IN_GATED = pci_live ? PCI_IN_PINS : 8'h00;
  assign PCI_PIN_O = PCI_OUT_DATA;
  assign PCI_PIN_OE = pci_live ? PCI_OUT_EN_REQ : 8'h00;

  // per-class match gating
  // each class is enabled on its own by the MAC configure setting
  genvar gi;
  generate
    for (gi = 0; gi < iso_rst_pkg::NUM_CLASSES; gi++) begin : g_class
      assign class_ok[gi] = RX_CLASS_HIT[gi] & CFG_CLASS_EN[gi];
    end
  endgenerate

  // packet window, class capture and link change
  // the byte counter stops one past the window, so later bytes cannot match
  // packet match is refused in D0: the host is awake and reads frames itself
  // link change is taken in every power state, either direction
  assign in_window = (cnt_ff <= iso_rst_pkg::WAKE_WINDOW_LAST);
  assign pkt_match = RX_FRAME_END & (|hit_ff) & CFG_PKT_WAKE_EN
    & (POWER_STATE != iso_rst_pkg::DSTATE_D0);
  assign link_evt = (LINK_VALID != link_ff) & CFG_LINK_WAKE_EN;

  always_comb begin
    nxt_cnt = cnt_ff;
    nxt_hit = hit_ff;
    nxt_len = len_ff;
    nxt_link = LINK_VALID;
    if (RX_BYTE_VALID) begin
      if (RX_FRAME_START) begin
        nxt_cnt = 8'h01;
        nxt_hit = class_ok;
      end else if (in_window) begin
        nxt_cnt = cnt_ff + 8'h01;
        nxt_hit = hit_ff | class_ok;
      end
    end
    if (RX_FRAME_END) begin
      if (pkt_match & PME_ENABLE & ~pme_ff) begin
        nxt_len = cnt_ff;
      end
      nxt_hit = 5'h00;
    end
    // set beats clear; enable-gated
    // a clear in the same cycle as a new event must not lose that event
    nxt_pme = pme_ff;
    if (PME_STATUS_CLR) begin
      nxt_pme = 1'b0;
    end
    if (PME_ENABLE & (pkt_match | link_evt)) begin
      nxt_pme = 1'b1;
    end
    if (ctx_rst_ff) begin
      nxt_pme = 1'b0;
      nxt_len = iso_rst_pkg::BYTE_CNT_RESET;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      cnt_ff <= iso_rst_pkg::BYTE_CNT_RESET;
      hit_ff <= 5'h00;
      len_ff <= iso_rst_pkg::BYTE_CNT_RESET;
      link_ff <= 1'b0;
      pme_ff <= 1'b0;
    end else if (CE) begin
      cnt_ff <= nxt_cnt;
      hit_ff <= nxt_hit;
      len_ff <= nxt_len;
      link_ff <= nxt_link;
      pme_ff <= nxt_pme;
    end
  end

  // stored frame bytes, kept across PCI reset while events enabled
  // frozen while an event is pending, so the host reads the frame that woke it
  // frame start writes slot 0 even when the old count sits past the window
  // the array has no reset: its contents are only meaningful after a match
  always_ff @(posedge CORE_CLK) begin
    if (CE & RX_BYTE_VALID & (RX_FRAME_START | in_window) & ~pme_ff) begin
      pkt_mem[RX_FRAME_START ? 7'h00 : cnt_ff[6:0]] <= RX_BYTE;
    end
    if (RST) begin
      pkt_q_ff <= 8'h00;
    end else if (CE) begin
      pkt_q_ff <= pkt_mem[PCI_IN_GATED[6:0]];
    end
  end

  // outputs: event pin open-drain low, never isolated
  // the event pin only pulls low; the enable is the whole of its drive
  // it ignores isolate and reset so a powered-off host can still be woken
  // gated by the enable bit and at least one MAC configure wake setting
  assign PME_N_O = 1'b0;
  assign PME_N_OE = pme_ff & PME_ENABLE & (CFG_LINK_WAKE_EN | CFG_PKT_WAKE_EN);
  assign INIT = init_ff;
  assign EVENT_CTX_RESET = ctx_rst_ff;
  assign PME_STATUS = pme_ff;
  assign BUS_WAKE = wake_ff;
  assign WAKE_PKT_BYTE = pkt_q_ff;
  assign WAKE_PKT_LEN = len_ff;
endmodule

// File: iso_rst_pkg.sv
/*
  constants for the PCI isolation, reset and wake control block.
  assumes one always-running auxiliary clock domain at 100 MHz.
*/
package iso_rst_pkg;
  localparam int unsigned CLK_MHZ = 100;
  localparam int unsigned WAKE_WINDOW_BYTES = 128;
  localparam logic [7:0] WAKE_WINDOW_LAST = 8'h7f;
  localparam logic [1:0] DSTATE_D0 = 2'h0;
  localparam logic [1:0] DSTATE_D1 = 2'h1;
  localparam logic [1:0] DSTATE_D2 = 2'h2;
  localparam logic [1:0] DSTATE_D3 = 2'h3;
  localparam logic [2:0] SYNC_RESET = 3'h0;
  localparam logic [7:0] BYTE_CNT_RESET = 8'h00;
  // packet class codes from the frame parser
  localparam int unsigned NUM_CLASSES = 5;
  localparam int unsigned CLASS_ARP = 0;
  localparam int unsigned CLASS_DIRECT = 1;
  localparam int unsigned CLASS_ND6 = 2;
  localparam int unsigned CLASS_NBT = 3;
  localparam int unsigned CLASS_DIAG = 4;
  typedef enum logic [2:0] {
    BUS_OFF = 3'b001,
    BUS_RESET = 3'b010,
    BUS_ON = 3'b100
  } bus_state_t;
endpackage

// File: iso_rst_checker_assertions.sv
/* port checker for the isolation, reset and wake block.
   bound from the testbench; assumes CE held high. */
`timescale 1ns/1ps
module iso_rst_checker (
  input wire logic CORE_CLK, // clock
  input wire logic RST, // reset
  input wire logic ALTERNATE_POR_N, // por
  input wire logic ISOLATE_N, // power good
  input wire logic PCI_RST_N, // pci reset
  input wire logic AUX_SUPPLY_SENSE, // aux
  input wire logic [1:0] POWER_STATE, // d state
  input wire logic PME_ENABLE, // enable bit
  input wire logic CFG_LINK_WAKE_EN, // link wake
  input wire logic LINK_VALID, // link
  input wire logic [7:0] PCI_PIN_OE, // pin enables
  input wire logic [7:0] PCI_IN_GATED, // gated inputs
  input wire logic PME_N_O, // event out
  input wire logic PME_N_OE, // event enable
  input wire logic INIT, // init
  input wire logic PME_STATUS, // pending
  input wire logic BUS_WAKE // b3 to b0
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (RST);
  // pins take a few edges through the filter
  a_iso_inputs_off: assert property ((!ISOLATE_N)[*6] |-> PCI_IN_GATED == 8'h00)
    else $error("inputs seen while isolated");
  a_iso_outputs_float: assert property ((!ISOLATE_N)[*6] |-> PCI_PIN_OE == 8'h00 && !PME_N_O)
    else $error("outputs driven while isolated");
  a_rst_outputs_float: assert property ((!PCI_RST_N && !AUX_SUPPLY_SENSE)[*6] |-> !PCI_PIN_OE)
    else $error("outputs driven in reset");
  a_level_init: assert property
    ((ISOLATE_N && !PCI_RST_N && !AUX_SUPPLY_SENSE && POWER_STATE != 2'h3)[*6] |-> INIT)
    else $error("init not held by reset level");
  a_aux_no_init: assert property ((AUX_SUPPLY_SENSE && ISOLATE_N && ALTERNATE_POR_N)[*8] |-> !INIT)
    else $error("init with aux supply");
  a_link_event: assert property (PME_ENABLE && CFG_LINK_WAKE_EN && ALTERNATE_POR_N
    && $changed(LINK_VALID) |=> PME_STATUS && PME_N_OE)
    else $error("link change lost");
  a_no_wake_off: assert property (!PME_ENABLE && !PME_STATUS |=> !PME_STATUS)
    else $error("event while disabled");
  a_event_gated: assert property (PME_N_OE |-> PME_ENABLE && PME_STATUS)
    else $error("event pin ungated");
  a_wake_pulse: assert property (BUS_WAKE |-> PCI_RST_N ##1 !BUS_WAKE)
    else $error("bad bus wake pulse");
  a_por_init: assert property ((!ALTERNATE_POR_N)[*6] |-> INIT && !PME_STATUS)
    else $error("por did not initialize");
  c_wake: cover property (BUS_WAKE);
  c_event: cover property ($rose(PME_N_OE));
  c_d3_init: cover property ($rose(INIT) && POWER_STATE == 2'h3);
endmodule

// File: pci_host_model.sv
/* far side: pci power good and reset source.
   reset is only released while power good is high. */
`timescale 1ns/1ps
module pci_host_model (
  input wire logic clk, // core clock
  input wire logic bus_on, // bus power request
  input wire logic rst_req, // extra reset request
  output logic isolate_n, // power good
  output logic pci_rst_n, // pci reset
  output logic [7:0] pins // pci input lines
);
  logic [7:0] on_ff = 8'h00;
  initial pins = 8'h00;
  // released lines wander so stale values cannot pass
  always @(posedge clk) begin
    on_ff <= {on_ff[6:0], bus_on};
    pins <= isolate_n ? 8'h5a : ~pins;
  end
  assign isolate_n = |on_ff;
  assign pci_rst_n = &on_ff && !rst_req;
endmodule

// File: pci_isolation_reset_wake_control_test.sv
/* self-checking bench for the isolation, reset and wake block.
   inputs change at the falling edge; the host model drives the pci pins. */
`timescale 1ns/1ps
module pci_isolation_reset_wake_control_test;
  logic clk, rst, por_n, aux, pme_en, pme_clr, cfg_link, cfg_pkt, link, rx_v, rx_s, rx_e;
  logic bus_on, rst_req, init_d;
  logic [1:0] dst;
  logic [4:0] hit;
  logic [7:0] rx_b;
  wire [7:0] pkt_len, pkt_byte;
  wire iso_n, prst_n, pme_o, pme_oe, init, ctx, pme_st, bwake;
  wire [7:0] pins, gated, pin_oe;
  int mismatches, comparisons, inits, wakes, ticks;
  pci_host_model host (.clk(clk), .bus_on(bus_on), .rst_req(rst_req), .isolate_n(iso_n),
    .pci_rst_n(prst_n), .pins(pins));
  pci_isolation_reset_wake_control dut (.CORE_CLK(clk), .RST(rst), .CE(1'b1),
    .ALTERNATE_POR_N(por_n), .ISOLATE_N(iso_n), .PCI_RST_N(prst_n), .AUX_SUPPLY_SENSE(aux),
    .POWER_STATE(dst), .PME_ENABLE(pme_en), .PME_STATUS_CLR(pme_clr), .CFG_LINK_WAKE_EN(cfg_link),
    .CFG_PKT_WAKE_EN(cfg_pkt), .CFG_CLASS_EN(5'h1f), .LINK_VALID(link), .RX_BYTE_VALID(rx_v),
    .RX_FRAME_START(rx_s), .RX_FRAME_END(rx_e), .RX_CLASS_HIT(hit), .RX_BYTE(rx_b),
    .PCI_OUT_DATA(8'h3c), .PCI_OUT_EN_REQ(8'hff), .PCI_IN_PINS(pins), .PCI_IN_GATED(gated),
    .PCI_PIN_O(), .PCI_PIN_OE(pin_oe), .PME_N_O(pme_o), .PME_N_OE(pme_oe), .INIT(init),
    .EVENT_CTX_RESET(ctx), .PME_STATUS(pme_st), .BUS_WAKE(bwake), .WAKE_PKT_BYTE(pkt_byte),
    .WAKE_PKT_LEN(pkt_len));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic conclude;
    if (mismatches == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic clr;
    pme_clr = 1'b1;
    cyc(1);
    pme_clr = 1'b0;
    cyc(1);
  endtask
  // one frame of 130 bytes with class hits at one byte
  task automatic frame(input int pos, input logic [4:0] h);
    for (int i = 0; i < 130; i++) begin
      rx_v = 1'b1;
      rx_s = (i == 0);
      hit = (i == pos) ? h : 5'h00;
      rx_b = i[7:0];
      cyc(1);
    end
    rx_v = 1'b0;
    hit = 5'h00;
    rx_e = 1'b1;
    cyc(1);
    rx_e = 1'b0;
    cyc(2);
  endtask
  // init rises, bus wake cycles and the run limit
  always @(posedge clk) begin
    init_d <= init;
    ticks++;
    if (init && !init_d) inits++;
    if (bwake) wakes++;
    if (ticks == 3000) begin
      mismatches++;
      conclude();
    end
  end
  initial begin
    {rst, por_n, aux, pme_en, pme_clr, cfg_link, cfg_pkt, link} = 8'h c0;
    {rx_v, rx_s, rx_e, bus_on, rst_req, init_d} = 6'h00;
    dst = 2'h0;
    hit = 5'h00;
    rx_b = 8'h00;
    cyc(6);
    rst = 1'b0;
    cyc(10);
    chk(pin_oe, 8'h00);
    chk(gated, 8'h00);
    bus_on = 1'b1;
    cyc(7);
    chk(init, 1'b1);
    chk(pin_oe, 8'h00);
    cyc(8);
    chk(init, 1'b0);
    chk(pin_oe, 8'hff);
    chk(gated, 8'h5a);
    chk(8'(wakes), 8'h01);
    pme_en = 1'b1;
    cfg_link = 1'b1;
    for (int d = 0; d < 4; d++) begin
      dst = d[1:0];
      link = !link;
      cyc(2);
      chk(pme_st, 1'b1);
      chk(pme_oe, 1'b1);
      clr();
    end
    cfg_link = 1'b0;
    link = !link;
    cyc(2);
    chk(pme_st, 1'b0);
    pme_en = 1'b0;
    cfg_link = 1'b1;
    link = !link;
    cyc(2);
    chk(pme_oe, 1'b0);
    pme_en = 1'b1;
    dst = 2'h0;
    aux = 1'b1;
    rst_req = 1'b1;
    cyc(8);
    chk(init, 1'b0);
    chk(pin_oe, 8'hff);
    rst_req = 1'b0;
    cyc(6);
    chk(8'(wakes), 8'h01);
    aux = 1'b0;
    dst = 2'h3;
    link = !link;
    cyc(2);
    inits = 0;
    rst_req = 1'b1;
    cyc(8);
    chk(init, 1'b0);
    chk(pin_oe, 8'h00);
    rst_req = 1'b0;
    cyc(6);
    chk(8'(inits), 8'h01);
    chk(pme_st, 1'b1);
    chk(8'(wakes), 8'h02);
    bus_on = 1'b0;
    cyc(14);
    chk(pin_oe, 8'h00);
    chk(pme_oe, 1'b1);
    inits = 0;
    bus_on = 1'b1;
    cyc(16);
    chk(8'(inits), 8'h02);
    chk(pme_st, 1'b1);
    clr();
    dst = 2'h1;
    cfg_link = 1'b0;
    cfg_pkt = 1'b1;
    frame(128, 5'h1f);
    chk(pme_st, 1'b0);
    for (int k = 0; k < 5; k++) begin
      frame(127, 5'h01 << k);
      chk(pme_st, 1'b1);
      chk(pkt_len, 8'h80);
      clr();
    end
    cfg_link = 1'b1;
    link = !link;
    cyc(2);
    por_n = 1'b0;
    cyc(7);
    chk(init, 1'b1);
    chk(pme_st, 1'b0);
    chk(ctx, 1'b1);
    por_n = 1'b1;
    cyc(8);
    chk(init, 1'b0);
    chk(pkt_byte, 8'h5a);
    conclude();
  end
endmodule
bind pci_isolation_reset_wake_control iso_rst_checker u_chk (.CORE_CLK(CORE_CLK), .RST(RST),
  .ALTERNATE_POR_N(ALTERNATE_POR_N), .ISOLATE_N(ISOLATE_N), .PCI_RST_N(PCI_RST_N),
  .AUX_SUPPLY_SENSE(AUX_SUPPLY_SENSE), .POWER_STATE(POWER_STATE), .PME_ENABLE(PME_ENABLE),
  .CFG_LINK_WAKE_EN(CFG_LINK_WAKE_EN), .LINK_VALID(LINK_VALID), .PCI_PIN_OE(PCI_PIN_OE),
  .PCI_IN_GATED(PCI_IN_GATED), .PME_N_O(PME_N_O), .PME_N_OE(PME_N_OE), .INIT(INIT),
  .PME_STATUS(PME_STATUS), .BUS_WAKE(BUS_WAKE));
